// ==== hw/diag_port_pkg.sv ====
package diag_port_pkg;
    localparam logic [3:0] PORT_BUF_LO   = 4'h0;
    localparam logic [3:0] PORT_BUF_HI   = 4'h1;
    localparam logic [3:0] PORT_STATE    = 4'h2;
    localparam logic [3:0] PORT_STATUS   = 4'h3;
    localparam logic [3:0] PORT_MODE     = 4'h4;
    localparam logic [3:0] PORT_INIT     = 4'h5;
    localparam logic [3:0] PORT_SPARE6   = 4'h6;
    localparam logic [3:0] PORT_SPARE7   = 4'h7;
    localparam logic [3:0] PORT_SPARE8   = 4'h8;
    localparam int         PORT_COUNT    = 9;
    // mode control fields
    localparam int         MODE_ECHO_BIT = 0;
    localparam int         MODE_PASS_BIT = 1;
    // init control fields
    localparam int         INIT_START_BIT  = 0;
    localparam int         INIT_CENTRAL_BIT = 1;
    localparam int         INIT_RETURN_BIT = 2;
    // status port fields
    localparam int         STAT_ERR_BIT   = 0;
    localparam int         STAT_ALARM_BIT = 1;
    localparam int         STAT_INIT_BIT  = 2;
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    localparam logic [15:0] RESET_WORD    = 16'h0000;
    localparam logic [7:0] SPARE_READ     = 8'h00;
    // step pulse states
    typedef enum logic [1:0] {
        STEP_IDLE  = 2'b00,
        STEP_HIGH  = 2'b01,
        STEP_WAIT  = 2'b10
    } step_state_t;
endpackage

// ==== hw/capture_reg.sv ====
`timescale 1ns/100ps
module capture_reg
    import diag_port_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // load side
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] din,
    // stored word
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] word_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            word_ff <= '0;
        end else if (load) begin
            word_ff <= din;
        end
    end

    assign dout = word_ff;
endmodule

// ==== hw/interface_board_diag_ports.sv ====
`timescale 1ns/100ps
// Summary of operation
// RULE1: nine byte ports, six of them used
// RULE2: port0 low, port1 high buffer byte
// RULE3: buffer ports active only in pass
// RULE4: port2 low nibble shows machine state
// RULE5: port2 high nibble shows access kind
// RULE6: port3 shows error, alarm, init
// RULE7: port4 selects echo and pass
// RULE8: port5 start, central init, return mode
// RULE9: pass disables chip, stops board clock
// RULE10: each port1 access in pass gives one pulse
// RULE11: pass combines with echo and return
// RULE12: host uses pass only for diagnostics
// RULE13: echo disables link cable drivers
// RULE14: echo captures outgoing word in registers
// RULE15: echo answers reads from capture
// RULE16: return mode disables central bus drivers
// RULE17: return mode stepped in pass, else free
// RULE18: modes cleared at reset, held until written
module interface_board_diag_ports
    import diag_port_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // host port access
    input  wire logic [3:0]  port_addr,
    input  wire logic        port_rd,
    input  wire logic        port_wr,
    input  wire logic [7:0]  port_wdata,
    output logic      [7:0]  port_rdata_ff,
    // interface processor observation
    input  wire logic [3:0]  ip_state,
    input  wire logic        ip_access_write,
    input  wire logic [2:0]  ip_access_len,
    input  wire logic        link_error,
    input  wire logic        link_alarm,
    input  wire logic        link_init,
    // outgoing link word from the processor path
    input  wire logic        ip_out_valid,
    input  wire logic [15:0] ip_out_word,
    // word from memory subsystem
    input  wire logic [15:0] link_in_word,
    // board controls
    output logic             ip_chip_en_ff,
    output logic             board_clk_run_ff,
    output logic             board_clk_step_ff,
    output logic             cable_drv_en_ff,
    output logic             central_bus_drv_en_ff,
    output logic             return_mode_ff,
    output logic             board_start_ff,
    output logic             central_init_ff,
    output logic             pass_out_valid_ff,
    output logic      [15:0] pass_out_word_ff
);
    logic        echo_ff;
    logic        pass_ff;
    logic [7:0]  buf_lo_ff;
    logic [15:0] capture_q;
    logic        capture_load;
    logic [15:0] capture_din;
    logic [15:0] rd_word;
    logic [7:0]  nxt_rdata;
    logic        buf_hi_hit;
    step_state_t step_ff;

    assign buf_hi_hit = (port_rd || port_wr) && (port_addr == PORT_BUF_HI);

    // mode selections
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            echo_ff <= 1'b0; // RULE18
            pass_ff <= 1'b0; // RULE18
        end else if (port_wr && port_addr == PORT_MODE) begin
            echo_ff <= port_wdata[MODE_ECHO_BIT]; // RULE7 RULE11
            pass_ff <= port_wdata[MODE_PASS_BIT]; // RULE7 RULE11
        end
    end

    // initialization control
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            board_start_ff  <= 1'b0; // RULE18
            central_init_ff <= 1'b0;
            return_mode_ff  <= 1'b0;
        end else if (port_wr && port_addr == PORT_INIT) begin
            board_start_ff  <= port_wdata[INIT_START_BIT]; // RULE8
            central_init_ff <= port_wdata[INIT_CENTRAL_BIT]; // RULE8
            return_mode_ff  <= port_wdata[INIT_RETURN_BIT]; // RULE8
        end
    end

    // derived board controls
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ip_chip_en_ff         <= 1'b1;
            board_clk_run_ff      <= 1'b1;
            cable_drv_en_ff       <= 1'b1;
            central_bus_drv_en_ff <= 1'b1;
        end else begin
            ip_chip_en_ff         <= !pass_ff; // RULE9
            board_clk_run_ff      <= !pass_ff; // RULE9 RULE17
            cable_drv_en_ff       <= !echo_ff; // RULE13
            central_bus_drv_en_ff <= !return_mode_ff; // RULE16
        end
    end

    // link buffer bytes, host writable only in pass
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            buf_lo_ff <= RESET_BYTE;
        end else if (pass_ff && port_wr && port_addr == PORT_BUF_LO) begin
            buf_lo_ff <= port_wdata; // RULE2 RULE3
        end
    end

    // one board clock pulse per port1 access in pass
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_ff           <= STEP_IDLE;
            board_clk_step_ff <= 1'b0;
        end else begin
            case (step_ff)
                STEP_IDLE: begin
                    board_clk_step_ff <= 1'b0;
                    if (pass_ff && buf_hi_hit) begin
                        step_ff           <= STEP_HIGH;
                        board_clk_step_ff <= 1'b1; // RULE10 RULE17
                    end
                end
                STEP_HIGH: begin
                    board_clk_step_ff <= 1'b0;
                    step_ff           <= buf_hi_hit ? STEP_WAIT : STEP_IDLE;
                end
                STEP_WAIT: begin
                    board_clk_step_ff <= 1'b0;
                    if (!buf_hi_hit) begin
                        step_ff <= STEP_IDLE;
                    end
                end
                default: begin
                    board_clk_step_ff <= 1'b0;
                    step_ff           <= STEP_IDLE;
                end
            endcase
        end
    end

    // word driven toward the link in pass
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pass_out_valid_ff <= 1'b0;
            pass_out_word_ff  <= RESET_WORD;
        end else begin
            pass_out_valid_ff <= pass_ff && port_wr && port_addr == PORT_BUF_HI; // RULE3
            if (pass_ff && port_wr && port_addr == PORT_BUF_HI) begin
                pass_out_word_ff <= {port_wdata, buf_lo_ff};
            end
        end
    end

    // echo capture at the driver point
    always_comb begin
        capture_load = 1'b0;
        capture_din  = ip_out_word;
        if (echo_ff) begin
            if (pass_ff && port_wr && port_addr == PORT_BUF_HI) begin
                capture_load = 1'b1; // RULE14
                capture_din  = {port_wdata, buf_lo_ff};
            end else if (!pass_ff && ip_out_valid) begin
                capture_load = 1'b1; // RULE14
            end
        end
    end

    capture_reg #(
        .WIDTH (16)
    ) u_capture (
        .clk   (clk),
        .rst_b (rst_b),
        .load  (capture_load),
        .din   (capture_din),
        .dout  (capture_q)
    );

    assign rd_word = echo_ff ? capture_q : link_in_word; // RULE15

    // read multiplexer
    always_comb begin
        nxt_rdata = SPARE_READ;
        case (port_addr)
            PORT_BUF_LO: nxt_rdata = pass_ff ? rd_word[7:0] : SPARE_READ; // RULE2 RULE3 RULE15
            PORT_BUF_HI: nxt_rdata = pass_ff ? rd_word[15:8] : SPARE_READ; // RULE2 RULE3 RULE15
            PORT_STATE:  nxt_rdata = {ip_access_write, ip_access_len, ip_state}; // RULE4 RULE5
            PORT_STATUS: nxt_rdata = {5'h00, link_init, link_alarm, link_error}; // RULE6
            PORT_MODE:   nxt_rdata = {6'h00, pass_ff, echo_ff};
            PORT_INIT:   nxt_rdata = {5'h00, return_mode_ff, central_init_ff, board_start_ff};
            PORT_SPARE6: nxt_rdata = SPARE_READ; // RULE1
            PORT_SPARE7: nxt_rdata = SPARE_READ; // RULE1
            PORT_SPARE8: nxt_rdata = SPARE_READ; // RULE1
            default:     nxt_rdata = SPARE_READ;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_rdata_ff <= RESET_BYTE;
        end else if (port_rd) begin
            port_rdata_ff <= nxt_rdata;
        end
    end

    // host keeps pass for diagnostics only; nothing enforced here (RULE12)

    property p_mode_write;
        @(posedge clk) disable iff (!rst_b)
        port_wr && port_addr == PORT_MODE |=> pass_ff == $past(port_wdata[MODE_PASS_BIT]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // RULE7

    property p_clk_stop;
        @(posedge clk) disable iff (!rst_b)
        pass_ff |=> !board_clk_run_ff && !ip_chip_en_ff;
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("clock runs in pass"); // RULE9

    property p_one_pulse;
        @(posedge clk) disable iff (!rst_b)
        board_clk_step_ff |=> !board_clk_step_ff;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("pulse too long"); // RULE10

    property p_pulse_cause;
        @(posedge clk) disable iff (!rst_b)
        $rose(board_clk_step_ff) |-> $past(pass_ff && buf_hi_hit);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without access"); // RULE10

    property p_echo_drv;
        @(posedge clk) disable iff (!rst_b)
        echo_ff |=> !cable_drv_en_ff;
    endproperty
    a_echo_drv: assert property (p_echo_drv) else $error("drivers on in echo"); // RULE13

    property p_return_drv;
        @(posedge clk) disable iff (!rst_b)
        return_mode_ff |=> !central_bus_drv_en_ff;
    endproperty
    a_return_drv: assert property (p_return_drv) else $error("bus drivers on"); // RULE16

    property p_echo_capture;
        @(posedge clk) disable iff (!rst_b)
        echo_ff && !pass_ff && ip_out_valid |=> capture_q == $past(ip_out_word);
    endproperty
    a_echo_capture: assert property (p_echo_capture) else $error("capture missed"); // RULE14

    property p_status_read;
        @(posedge clk) disable iff (!rst_b)
        port_rd && port_addr == PORT_STATE |=> port_rdata_ff[3:0] == $past(ip_state);
    endproperty
    a_status_read: assert property (p_status_read) else $error("state read wrong"); // RULE4

    property p_buf_unused;
        @(posedge clk) disable iff (!rst_b)
        port_rd && port_addr == PORT_BUF_LO && !pass_ff |=> port_rdata_ff == SPARE_READ;
    endproperty
    a_buf_unused: assert property (p_buf_unused) else $error("buffer used outside pass"); // RULE3

    property p_pass_read;
        @(posedge clk) disable iff (!rst_b)
        pass_ff && !echo_ff && port_rd && port_addr == PORT_BUF_HI |=> port_rdata_ff == $past(link_in_word[15:8]);
    endproperty
    a_pass_read: assert property (p_pass_read) else $error("memory word not returned"); // RULE15

    property p_echo_read;
        @(posedge clk) disable iff (!rst_b)
        pass_ff && echo_ff && port_rd && port_addr == PORT_BUF_LO |=> port_rdata_ff == $past(capture_q[7:0]);
    endproperty
    a_echo_read: assert property (p_echo_read) else $error("capture not returned"); // RULE15

    property p_status_port;
        @(posedge clk) disable iff (!rst_b)
        port_rd && port_addr == PORT_STATUS
            |=> port_rdata_ff == {5'h00, $past(link_init), $past(link_alarm), $past(link_error)};
    endproperty
    a_status_port: assert property (p_status_port) else $error("status read wrong"); // RULE6

    property p_access_read;
        @(posedge clk) disable iff (!rst_b)
        port_rd && port_addr == PORT_STATE |=> port_rdata_ff[7:4] == {$past(ip_access_write), $past(ip_access_len)};
    endproperty
    a_access_read: assert property (p_access_read) else $error("access kind read wrong"); // RULE5

    property p_buf_refused;
        @(posedge clk) disable iff (!rst_b)
        !pass_ff && port_wr && port_addr == PORT_BUF_LO |=> $stable(buf_lo_ff);
    endproperty
    a_buf_refused: assert property (p_buf_refused) else $error("buffer written outside pass"); // RULE3

    property p_pass_word;
        @(posedge clk) disable iff (!rst_b)
        pass_ff && port_wr && port_addr == PORT_BUF_HI
            |=> pass_out_valid_ff && pass_out_word_ff == {$past(port_wdata), $past(buf_lo_ff)};
    endproperty
    a_pass_word: assert property (p_pass_word) else $error("pass word wrong"); // RULE2

    property p_no_step;
        @(posedge clk) disable iff (!rst_b)
        !pass_ff |=> !board_clk_step_ff;
    endproperty
    a_no_step: assert property (p_no_step) else $error("pulse outside pass"); // RULE10

    property p_mode_hold;
        @(posedge clk) disable iff (!rst_b)
        !(port_wr && port_addr == PORT_MODE) |=> $stable(pass_ff) && $stable(echo_ff);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed unwritten"); // RULE18

    property p_init_hold;
        @(posedge clk) disable iff (!rst_b)
        !(port_wr && port_addr == PORT_INIT)
            |=> $stable(return_mode_ff) && $stable(board_start_ff) && $stable(central_init_ff);
    endproperty
    a_init_hold: assert property (p_init_hold) else $error("init bits changed unwritten"); // RULE18

    property p_init_write;
        @(posedge clk) disable iff (!rst_b)
        port_wr && port_addr == PORT_INIT |=> return_mode_ff == $past(port_wdata[INIT_RETURN_BIT])
            && central_init_ff == $past(port_wdata[INIT_CENTRAL_BIT]);
    endproperty
    a_init_write: assert property (p_init_write) else $error("init write lost"); // RULE8

    property p_spare_read;
        @(posedge clk) disable iff (!rst_b)
        port_rd && port_addr > PORT_INIT |=> port_rdata_ff == SPARE_READ;
    endproperty
    a_spare_read: assert property (p_spare_read) else $error("spare port not zero"); // RULE1

    property p_free_run;
        @(posedge clk) disable iff (!rst_b)
        !pass_ff |=> board_clk_run_ff && ip_chip_en_ff;
    endproperty
    a_free_run: assert property (p_free_run) else $error("clock stopped outside pass"); // RULE17

    property p_echo_pass_capture;
        @(posedge clk) disable iff (!rst_b)
        echo_ff && pass_ff && port_wr && port_addr == PORT_BUF_HI
            |=> capture_q == {$past(port_wdata), $past(buf_lo_ff)};
    endproperty
    a_echo_pass_capture: assert property (p_echo_pass_capture) else $error("pass capture missed"); // RULE14

    c_step: cover property (@(posedge clk) disable iff (!rst_b) board_clk_step_ff);
    c_pass_read: cover property (@(posedge clk) disable iff (!rst_b) pass_ff && !echo_ff && port_rd && buf_hi_hit);
    c_refused: cover property (@(posedge clk) disable iff (!rst_b) !pass_ff && port_wr && port_addr == PORT_BUF_LO);
    c_echo: cover property (@(posedge clk) disable iff (!rst_b) echo_ff && pass_ff);
    c_return: cover property (@(posedge clk) disable iff (!rst_b) return_mode_ff && !pass_ff);
endmodule

// ==== verification/far_side_model.sv ====
`timescale 1ns/100ps
module far_side_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // board clock from the block
    input  wire logic        clk_run,
    input  wire logic        clk_step,
    // scenario commands
    input  wire logic        send,
    input  wire logic [15:0] send_word,
    input  wire logic [2:0]  stat,
    // toward the block
    output logic      [3:0]  ip_state,
    output logic             ip_access_write,
    output logic      [2:0]  ip_access_len,
    output logic             link_error,
    output logic             link_alarm,
    output logic             link_init,
    output logic             ip_out_valid,
    output logic      [15:0] ip_out_word,
    output logic      [15:0] link_in_word
);
    logic [3:0] state_ff;

    // machine moves only on a board clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            state_ff <= 4'h0;
        else if (clk_run || clk_step)
            state_ff <= state_ff + 4'h1;
    end

    // outgoing word is junk outside its pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ip_out_valid <= 1'b0;
            ip_out_word  <= 16'h0000;
        end else begin
            ip_out_valid <= send;
            ip_out_word  <= send ? send_word : ~ip_out_word;
        end
    end

    assign ip_state        = state_ff;
    assign ip_access_write = state_ff[0];
    assign ip_access_len   = state_ff[3:1];
    assign link_error      = stat[0];
    assign link_alarm      = stat[1];
    assign link_init       = stat[2];
    // memory word follows the machine, so it holds while the board clock is stopped
    assign link_in_word    = {state_ff, ~state_ff, state_ff, ~state_ff};
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    import diag_port_pkg::*;
    logic        clk;
    logic        rst_b;
    logic [3:0]  port_addr;
    logic        port_rd;
    logic        port_wr;
    logic [7:0]  port_wdata;
    logic [7:0]  port_rdata_ff;
    logic [3:0]  ip_state;
    logic        ip_access_write;
    logic [2:0]  ip_access_len;
    logic        link_error;
    logic        link_alarm;
    logic        link_init;
    logic        ip_out_valid;
    logic [15:0] ip_out_word;
    logic [15:0] link_in_word;
    logic        ip_chip_en_ff;
    logic        board_clk_run_ff;
    logic        board_clk_step_ff;
    logic        cable_drv_en_ff;
    logic        central_bus_drv_en_ff;
    logic        return_mode_ff;
    logic        board_start_ff;
    logic        central_init_ff;
    logic        pass_out_valid_ff;
    logic [15:0] pass_out_word_ff;
    logic        send;
    logic [15:0] send_word;
    logic [2:0]  stat;
    logic [7:0]  d;
    logic [3:0]  s;
    logic [15:0] pv_word;
    int          err_count;
    int          cmp_count;
    int          step_cnt;
    int          n;

    interface_board_diag_ports interface_board_diag_ports_inst (.*);
    far_side_model far_side_model_inst (.clk(clk), .rst_b(rst_b), .clk_run(board_clk_run_ff),
        .clk_step(board_clk_step_ff), .send(send), .send_word(send_word), .stat(stat),
        .ip_state(ip_state), .ip_access_write(ip_access_write), .ip_access_len(ip_access_len),
        .link_error(link_error), .link_alarm(link_alarm), .link_init(link_init),
        .ip_out_valid(ip_out_valid), .ip_out_word(ip_out_word), .link_in_word(link_in_word));

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        if (board_clk_step_ff === 1'b1) step_cnt++;
        if (pass_out_valid_ff === 1'b1) pv_word = pass_out_word_ff;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        port_addr  <= a;
        port_wdata <= v;
        port_wr    <= 1'b1;
        @(posedge clk);
        port_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        port_addr <= a;
        port_rd   <= 1'b1;
        @(posedge clk);
        port_rd   <= 1'b0;
        @(posedge clk);
        #1 v = port_rdata_ff;
    endtask

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #20000;
        err_count++;
        test_done();
    end

    initial begin
        clk = 0; rst_b = 0; port_addr = 4'h0; port_rd = 0; port_wr = 0; port_wdata = 8'h00;
        send = 0; send_word = 16'h0000; stat = 3'b000;
        err_count = 0; cmp_count = 0; step_cnt = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        settle();
        chk("enables", 4'hF, {ip_chip_en_ff, board_clk_run_ff, cable_drv_en_ff, central_bus_drv_en_ff});
        chk("init bits", 3'h0, {return_mode_ff, board_start_ff, central_init_ff});
        $display("test reset done");
        stat <= 3'b101;
        rd(PORT_STATUS, d); chk("status", 8'h05, d);
        wr(PORT_SPARE6, 8'hFF);
        rd(PORT_SPARE6, d); chk("spare", SPARE_READ, d);
        wr(PORT_BUF_LO, 8'hAA);
        wr(PORT_BUF_HI, 8'h55);
        rd(PORT_BUF_LO, d); chk("buf off", 8'h00, d);
        chk("steps off", 16'h0, step_cnt);
        $display("test refusal done");
        wr(PORT_MODE, 8'h02);
        settle();
        chk("pass ctl", 2'b00, {ip_chip_en_ff, board_clk_run_ff});
        s = ip_state;
        n = step_cnt;
        wr(PORT_BUF_LO, 8'hAA);
        wr(PORT_BUF_HI, 8'h55);
        settle();
        chk("word", 16'h55AA, pv_word);
        chk("steps", n + 1, step_cnt);
        s = s + 4'h1;
        rd(PORT_STATE, d); chk("state", {s[0], s[3:1], s}, d);
        rd(PORT_BUF_LO, d); chk("buf lo", {s, ~s}, d);
        rd(PORT_BUF_HI, d); chk("buf hi", {s, ~s}, d);
        chk("read step", n + 2, step_cnt);
        $display("test pass done");
        wr(PORT_MODE, 8'h01);
        settle();
        chk("echo ctl", 2'b01, {cable_drv_en_ff, board_clk_run_ff});
        @(posedge clk);
        send      <= 1'b1;
        send_word <= 16'h1234;
        @(posedge clk);
        send      <= 1'b0;
        settle();
        wr(PORT_MODE, 8'h03);
        settle();
        rd(PORT_BUF_LO, d); chk("cap lo", 8'h34, d);
        rd(PORT_BUF_HI, d); chk("cap hi", 8'h12, d);
        rd(PORT_MODE, d); chk("mode", 8'h03, d);
        wr(PORT_BUF_LO, 8'h5A);
        wr(PORT_BUF_HI, 8'hC3);
        rd(PORT_BUF_LO, d); chk("cap pass lo", 8'h5A, d);
        rd(PORT_BUF_HI, d); chk("cap pass hi", 8'hC3, d);
        chk("echo word", 16'hC35A, pv_word);
        $display("test echo done");
        wr(PORT_INIT, 8'h07);
        settle();
        chk("init bits", 3'h7, {return_mode_ff, board_start_ff, central_init_ff});
        chk("bus drv", 1'b0, central_bus_drv_en_ff);
        chk("stepped", 1'b0, board_clk_run_ff);
        rd(PORT_INIT, d); chk("init", 8'h07, d);
        wr(PORT_MODE, 8'h00);
        settle();
        chk("free run", 2'b11, {board_clk_run_ff, return_mode_ff});
        $display("test return done");
        test_done();
    end
endmodule
